// ==== hw/exvec_unit.sv ====
// Exception entry unit: interrupt mode decode, restart capture,
// pipeline cancel and vector redirect, plus boot and reset bases.
// Assumes requests come from same-clock pipeline logic, oldest first.
`timescale 1ns/10ps

// Behaviour
// - Three interrupt modes; compatibility mode after reset.
// - Mode decoded from boot select, vector enable, spacing, support flags.
// - Vector spacing forced to zero when no vectored mode is implemented.
// - Read-only flag reports external-controller mode support.
// - Precise exception captures faulting pc, or branch pc with slot flag.
// - Imprecise exceptions capture no restart address.
// - Precise exception stops sequence, loads restart, enters kernel, redirects fetch.
// - Precise exceptions cancel causing and younger work; errors and debug use own registers.
// - Precise exceptions in program order; restart address suffices.
// - Imprecise exception waits until its instruction has completed.
// - First fetch after reset goes to the boot vector.
// - One global boot base; a local reset base per virtual processor.
// - Legacy boot base forces bits 31:29 to 101.
// - Legacy bits 28:12 place the vector; default maps to 0x1FC00000.
// - Wide mode places boot vector anywhere in 4 GB with bits 31:12.
// - Wide mode vector lies in uncached direct physical window.
// - Use-global bit picks global base when 1, local base when 0.
// - Local reset base has the same legacy and wide behaviour.
// - Offsets 0x000 refill with exl clear, 0x180 general, 0x200 interrupt with enable.
module exvec_unit
    import exvec_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Exception request from the pipeline
    input wire exvec_req_t req_i,
    input wire logic imprecise_done_i,
    // Mode control fields
    input wire exvec_ctl_t ctl_i,
    input wire logic spacing_wr_i,
    input wire logic [4:0] spacing_wdata_i,
    // Global boot vector base register port
    input wire logic gbase_wr_i,
    input wire logic [31:0] gbase_wdata_i,
    // Local restart vector base register port
    input wire logic lbase_wr_i,
    input wire logic [31:0] lbase_wdata_i,
    // Register readback
    output logic [31:0] gbase_rdata_o,
    output logic [31:0] lbase_rdata_o,
    output logic [4:0] vector_spacing_o,
    output logic third_cfg_ext_ctrl_o,
    // Mode and state
    output exvec_mode_t int_mode_o,
    output logic kernel_mode_o,
    output logic slot_flag_o,
    // Restart addresses
    output logic [63:0] restart_address_o,
    output logic [63:0] error_restart_address_o,
    output logic [63:0] debug_restart_address_o,
    // Fetch redirect and pipeline cancel
    output logic redirect_o,
    output logic [63:0] redirect_addr_o,
    output logic cancel_o,
    output logic imprecise_taken_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_q1;
    logic rst_q2;
    logic rst_n;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    assign rst_n = rst_q2;

    // ------------------------------------------------------------------
    // Vector base registers
    // ------------------------------------------------------------------
    logic [19:0] gbase_field;
    logic gbase_wide;
    logic [19:0] lbase_field;
    logic lbase_wide;
    logic use_global;

    // One global base serves every virtual processor; this unit holds
    // the local base of its own virtual processor only.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gbase_field <= BASE_FIELD_RESET;
            gbase_wide <= BASE_WIDE_RESET;
        end else if (gbase_wr_i) begin
            gbase_field <= gbase_wdata_i[BASE_FIELD_MSB:BASE_FIELD_LSB];
            gbase_wide <= gbase_wdata_i[BASE_WIDE_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lbase_field <= BASE_FIELD_RESET;
            lbase_wide <= BASE_WIDE_RESET;
            use_global <= USE_GLOBAL_RESET;
        end else if (lbase_wr_i) begin
            lbase_field <= lbase_wdata_i[BASE_FIELD_MSB:BASE_FIELD_LSB];
            lbase_wide <= lbase_wdata_i[BASE_WIDE_BIT];
            use_global <= lbase_wdata_i[USE_GLOBAL_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gbase_rdata_o <= 32'h00000000;
            lbase_rdata_o <= 32'h00000000;
        end else begin
            gbase_rdata_o <= {gbase_field, 10'h000, gbase_wide, 1'b0};
            lbase_rdata_o <= {lbase_field, 10'h000, lbase_wide, use_global};
        end
    end

    // ------------------------------------------------------------------
    // Vector formation
    // ------------------------------------------------------------------
    logic [63:0] gbase_addr;
    logic [63:0] lbase_addr;

    exvec_base_form u_gbase (
        .base_field_i(gbase_field),
        .wide_i(gbase_wide),
        .base_o(gbase_addr)
    );

    exvec_base_form u_lbase (
        .base_field_i(lbase_field),
        .wide_i(lbase_wide),
        .base_o(lbase_addr)
    );

    // ------------------------------------------------------------------
    // Interrupt mode
    // ------------------------------------------------------------------
    logic [4:0] spacing;
    logic any_vectoring;
    exvec_mode_t next_mode;

    assign any_vectoring = ctl_i.vectored_support | ctl_i.ext_ctrl_support;

    // Spacing is cleared on the first edge with no vectored mode, so the
    // undefined mode combination lasts one cycle at most.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            spacing <= 5'h00;
        end else if (!any_vectoring) begin
            spacing <= 5'h00;
        end else if (spacing_wr_i) begin
            spacing <= spacing_wdata_i;
        end
    end

    always_comb begin
        if (ctl_i.boot_vector_select || !ctl_i.interrupt_vector_enable ||
            spacing == 5'h00) begin
            next_mode = EXVEC_MODE_COMPAT;
        end else if (ctl_i.ext_ctrl_support) begin
            next_mode = EXVEC_MODE_EXT_CTRL;
        end else if (ctl_i.vectored_support) begin
            next_mode = EXVEC_MODE_VECTORED;
        end else begin
            next_mode = EXVEC_MODE_COMPAT;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_mode_o <= EXVEC_MODE_COMPAT;
        end else begin
            int_mode_o <= next_mode;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vector_spacing_o <= 5'h00;
            third_cfg_ext_ctrl_o <= 1'b0;
        end else begin
            vector_spacing_o <= spacing;
            third_cfg_ext_ctrl_o <= ctl_i.ext_ctrl_support;
        end
    end

    // ------------------------------------------------------------------
    // Exception acceptance
    // ------------------------------------------------------------------
    logic boot_pending;
    logic imprecise_pending;
    exvec_kind_t imprecise_kind;
    logic take_precise;
    logic take_imprecise;
    logic [63:0] next_vector;
    logic [11:0] offset;
    exvec_kind_t take_kind;

    // The cycle after a precise take the pipeline still shows the cancelled
    // instruction; it must not raise a second, younger exception.
    assign take_precise = req_i.valid && req_i.precise &&
                          !boot_pending && !cancel_o;
    assign take_imprecise = imprecise_pending && imprecise_done_i &&
                            !take_precise && !boot_pending &&
                            !cancel_o;
    assign take_kind = take_precise ? req_i.kind : imprecise_kind;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_pending <= 1'b1;
        end else begin
            boot_pending <= 1'b0;
        end
    end

    // A new imprecise request wins over the clearing take.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            imprecise_pending <= 1'b0;
            imprecise_kind <= EXVEC_KIND_GENERAL;
        end else if (req_i.valid && !req_i.precise) begin
            imprecise_pending <= 1'b1;
            imprecise_kind <= req_i.kind;
        end else if (take_imprecise) begin
            imprecise_pending <= 1'b0;
        end
    end

    always_comb begin
        unique case (take_kind)
            EXVEC_KIND_REFILL: begin
                offset = ctl_i.exl ? OFS_GENERAL : OFS_REFILL;
            end
            EXVEC_KIND_INTERRUPT: begin
                offset = ctl_i.interrupt_vector_enable ?
                         OFS_INTERRUPT : OFS_GENERAL;
            end
            EXVEC_KIND_ERROR: begin
                offset = OFS_ERROR;
            end
            EXVEC_KIND_RESET: begin
                offset = OFS_REFILL;
            end
            default: begin
                offset = OFS_GENERAL;
            end
        endcase
    end

    always_comb begin
        if (boot_pending) begin
            next_vector = gbase_addr;
        end else if (take_kind == EXVEC_KIND_RESET) begin
            next_vector = use_global ? gbase_addr : lbase_addr;
        end else begin
            next_vector = gbase_addr | {52'h0000000000000, offset};
        end
    end

    // ------------------------------------------------------------------
    // Redirect, cancel and kernel entry
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            redirect_o <= 1'b0;
        end else begin
            redirect_o <= boot_pending || take_precise ||
                          take_imprecise;
        end
    end

    // The address loads every cycle to keep the path short, so it only
    // means something while the redirect pulse stands.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            redirect_addr_o <= 64'h0000000000000000;
        end else begin
            redirect_addr_o <= next_vector;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cancel_o <= 1'b0;
            imprecise_taken_o <= 1'b0;
        end else begin
            cancel_o <= take_precise;
            imprecise_taken_o <= take_imprecise;
        end
    end

    // Kernel mode is left only by the pipeline's return path, which is
    // outside this unit; the unit reports entry and holds it.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            kernel_mode_o <= 1'b1;
        end else if (take_precise || take_imprecise) begin
            kernel_mode_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Restart address capture
    // ------------------------------------------------------------------
    logic [63:0] restart_pc;

    assign restart_pc = req_i.in_slot ? req_i.branch_pc : req_i.pc;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            restart_address_o <= 64'h0000000000000000;
            error_restart_address_o <= 64'h0000000000000000;
            debug_restart_address_o <= 64'h0000000000000000;
            slot_flag_o <= 1'b0;
        end else if (take_precise) begin
            unique case (req_i.kind)
                EXVEC_KIND_ERROR: begin
                    error_restart_address_o <= restart_pc;
                end
                EXVEC_KIND_DEBUG: begin
                    debug_restart_address_o <= restart_pc;
                end
                default: begin
                    restart_address_o <= restart_pc;
                    slot_flag_o <= req_i.in_slot;
                end
            endcase
        end
    end

endmodule

// ==== hw/exvec_pkg.sv ====
// Package for the exception mode and boot vector block.
// Assumes one core clock domain; all users import the whole package.
package exvec_pkg;

    // ------------------------------------------------------------------
    // Vector base register layout
    // ------------------------------------------------------------------
    localparam int BASE_FIELD_LSB = 12;
    localparam int BASE_FIELD_MSB = 31;
    localparam int BASE_WIDE_BIT = 1;
    localparam int USE_GLOBAL_BIT = 0;
    localparam int LEGACY_LSB = 12;
    localparam int LEGACY_MSB = 28;
    localparam logic [2:0] LEGACY_TOP = 3'h5;
    localparam logic [19:0] BASE_FIELD_RESET = 20'hbfc00;
    localparam logic BASE_WIDE_RESET = 1'b0;
    localparam logic USE_GLOBAL_RESET = 1'b1;
    localparam logic [31:0] UNCACHED_WINDOW_HI = 32'h90000000;

    // ------------------------------------------------------------------
    // Vector offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_REFILL = 12'h000;
    localparam logic [11:0] OFS_GENERAL = 12'h180;
    localparam logic [11:0] OFS_INTERRUPT = 12'h200;
    localparam logic [11:0] OFS_ERROR = 12'h300;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EXVEC_MODE_COMPAT,
        EXVEC_MODE_VECTORED,
        EXVEC_MODE_EXT_CTRL
    } exvec_mode_t;

    typedef enum logic [2:0] {
        EXVEC_KIND_GENERAL,
        EXVEC_KIND_REFILL,
        EXVEC_KIND_INTERRUPT,
        EXVEC_KIND_ERROR,
        EXVEC_KIND_DEBUG,
        EXVEC_KIND_RESET
    } exvec_kind_t;

    typedef struct packed {
        logic valid;
        logic precise;
        exvec_kind_t kind;
        logic in_slot;
        logic [63:0] pc;
        logic [63:0] branch_pc;
    } exvec_req_t;

    typedef struct packed {
        logic boot_vector_select;
        logic interrupt_vector_enable;
        logic exl;
        logic vectored_support;
        logic ext_ctrl_support;
    } exvec_ctl_t;

endpackage

// ==== hw/exvec_base_form.sv ====
// Forms a 64-bit vector base from a base field and its wide-mode bit.
// Assumes purely combinational use inside the exception unit.
`timescale 1ns/10ps
module exvec_base_form
    import exvec_pkg::*;
(
    // Base register fields
    input wire logic [19:0] base_field_i,
    input wire logic wide_i,
    // Formed address
    output logic [63:0] base_o
);

    logic [31:0] legacy_addr;

    // The forced top bits put the vector in the uncached kernel segment.
    assign legacy_addr = {LEGACY_TOP,
                          base_field_i[LEGACY_MSB-LEGACY_LSB:0],
                          12'h000};

    always_comb begin
        if (wide_i) begin
            base_o = {UNCACHED_WINDOW_HI, base_field_i, 12'h000};
        end else begin
            base_o = {{32{legacy_addr[31]}}, legacy_addr};
        end
    end

endmodule

// ==== sim/exvec_unit_asserts.sv ====
// Checker for the exception unit, bound to its ports.
// Assumes one clock domain and the designer's reset timing.
`timescale 1ns/10ps
module exvec_unit_asserts
    import exvec_pkg::*;
(
    // Clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire exvec_req_t req_i,
    input wire logic imprecise_done_i,
    input wire exvec_ctl_t ctl_i,
    // Watched outputs
    input wire logic [31:0] gbase_rdata_o,
    input wire logic [31:0] lbase_rdata_o,
    input wire logic [4:0] vector_spacing_o,
    input wire logic third_cfg_ext_ctrl_o,
    input wire exvec_mode_t int_mode_o,
    input wire logic slot_flag_o,
    input wire logic [63:0] restart_address_o,
    input wire logic redirect_o,
    input wire logic [63:0] redirect_addr_o,
    input wire logic cancel_o,
    input wire logic imprecise_taken_o
);
    // The internal reset lags the pin, so requests count once settled.
    logic [3:0] up_cnt;
    logic ready;
    logic take;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'hf) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    assign ready = up_cnt > 4'h6;
    assign take = ready && req_i.valid && req_i.precise && !cancel_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    boot_fetch_a: assert property ($rose(resetn_i) |-> ##[1:4]
        redirect_o && redirect_addr_o == 64'hffffffffbfc00000)
        else $error("boot fetch wrong");
    precise_take_a: assert property (take |=> redirect_o
        && cancel_o) else $error("precise request not redirected");
    restart_cap_a: assert property (take && req_i.kind inside
        {EXVEC_KIND_GENERAL, EXVEC_KIND_REFILL} |=>
        slot_flag_o == $past(req_i.in_slot) && restart_address_o ==
        ($past(req_i.in_slot) ? $past(req_i.branch_pc) : $past(req_i.pc)))
        else $error("restart address wrong");
    gen_offset_a: assert property (take &&
        req_i.kind == EXVEC_KIND_GENERAL |=> redirect_addr_o[11:0] == 12'h180)
        else $error("general offset wrong");
    legacy_top_a: assert property (redirect_o && !gbase_rdata_o[1]
        && !lbase_rdata_o[1] |-> redirect_addr_o[63:29] == {32'hffffffff, 3'h5})
        else $error("legacy top bits wrong");
    impr_keep_a: assert property (imprecise_taken_o |->
        $stable(restart_address_o) && !cancel_o)
        else $error("imprecise touched restart");
    impr_wait_a: assert property (imprecise_taken_o |->
        $past(imprecise_done_i)) else $error("imprecise taken early");
    spacing_zero_a: assert property (!ctl_i.vectored_support &&
        !ctl_i.ext_ctrl_support ##1 !ctl_i.vectored_support &&
        !ctl_i.ext_ctrl_support ##1 !ctl_i.vectored_support &&
        !ctl_i.ext_ctrl_support |-> vector_spacing_o == 5'h0)
        else $error("spacing not held zero");
    bev_compat_a: assert property ($past(ctl_i.boot_vector_select) |->
        int_mode_o == EXVEC_MODE_COMPAT) else $error("boot select mode");
    ext_mode_a: assert property (ready && $stable(ctl_i) &&
        $stable(vector_spacing_o) && !ctl_i.boot_vector_select &&
        ctl_i.interrupt_vector_enable && ctl_i.ext_ctrl_support &&
        vector_spacing_o != 5'h0 |-> int_mode_o == EXVEC_MODE_EXT_CTRL)
        else $error("ext controller mode wrong");
    ext_flag_a: assert property (ready |-> third_cfg_ext_ctrl_o ==
        $past(ctl_i.ext_ctrl_support)) else $error("ext flag wrong");
endmodule
bind exvec_unit exvec_unit_asserts u_chk (.ref_clk_i, .resetn_i, .req_i,
    .imprecise_done_i, .ctl_i, .gbase_rdata_o, .lbase_rdata_o,
    .vector_spacing_o, .third_cfg_ext_ctrl_o, .int_mode_o, .slot_flag_o,
    .restart_address_o, .redirect_o, .redirect_addr_o, .cancel_o,
    .imprecise_taken_o);

// ==== sim/exvec_pipe_model.sv ====
// Pipeline side model: issues exception requests and completions.
// Assumes the unit's clock; all changes follow a rising edge.
`timescale 1ns/10ps
module exvec_pipe_model
    import exvec_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Towards the unit
    output exvec_req_t req_o,
    output logic done_o
);
    initial begin
        req_o = '0;
        done_o = 1'b0;
    end
    // Oldest first; n of 2 or more keeps younger work behind it.
    task automatic issue(input logic pr, input exvec_kind_t k,
                         input logic sl, input logic [63:0] pc, input int n);
        @(posedge clk_i);
        req_o <= '{1'b1, pr, k, sl, pc, pc - 64'h4};
        for (int i = 1; i <= n; i++) begin
            @(posedge clk_i);
            req_o.pc <= pc + 64'(4 * i);
        end
        req_o.valid <= 1'b0;
    endtask
    // A slow completion lets the unit show that it waits.
    task automatic complete(input int wait_n);
        repeat (wait_n) @(posedge clk_i);
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
    endtask
endmodule

// ==== sim/test_exception_mode_and_boot_vector.sv ====
// Self-checking bench for the exception mode and boot vector unit.
// Assumes the pipeline model for requests and write pulses for registers.
`timescale 1ns/10ps
module test_exception_mode_and_boot_vector
    import exvec_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    exvec_req_t req;
    logic done;
    exvec_ctl_t ctl = '0;
    logic sp_wr = 1'b0;
    logic [4:0] sp_d = 5'h0;
    logic gw = 1'b0;
    logic [31:0] gd = 32'h0;
    logic lw = 1'b0;
    logic [31:0] ld = 32'h0;
    logic [31:0] g_rd, l_rd;
    logic [4:0] vsp;
    exvec_mode_t mode;
    logic ecfg, kmode, slot, redir, canc, imp_t;
    logic [63:0] ra, era, dra, raddr;
    int n_fail = 0;
    int tests_run = 0;
    exvec_unit u_dut (.ref_clk_i(clk), .resetn_i(rst_n), .req_i(req),
        .imprecise_done_i(done), .ctl_i(ctl), .spacing_wr_i(sp_wr),
        .spacing_wdata_i(sp_d), .gbase_wr_i(gw), .gbase_wdata_i(gd),
        .lbase_wr_i(lw), .lbase_wdata_i(ld), .gbase_rdata_o(g_rd),
        .lbase_rdata_o(l_rd), .vector_spacing_o(vsp),
        .third_cfg_ext_ctrl_o(ecfg), .int_mode_o(mode), .kernel_mode_o(kmode),
        .slot_flag_o(slot), .restart_address_o(ra),
        .error_restart_address_o(era), .debug_restart_address_o(dra),
        .redirect_o(redir), .redirect_addr_o(raddr), .cancel_o(canc),
        .imprecise_taken_o(imp_t));
    exvec_pipe_model u_pipe (.clk_i(clk), .req_o(req), .done_o(done));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Select bits are spacing, global, local.
    task automatic wr(input logic [2:0] sel, input logic [31:0] d);
        @(posedge clk);
        {sp_wr, gw, lw} <= sel;
        sp_d <= d[4:0];
        gd <= d;
        ld <= d;
        @(posedge clk);
        {sp_wr, gw, lw} <= 3'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic t_boot();
        int k;
        k = 0;
        while (redir !== 1'b1 && k < 10) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("boot redirect", 64'h1, redir);
        chk("boot vector", 64'hffffffffbfc00000, raddr);
        chk("global reset", 64'hbfc00000, g_rd);
        chk("local reset", 64'hbfc00001, l_rd);
        chk("reset mode", EXVEC_MODE_COMPAT, mode);
        repeat (6) @(posedge clk);
        $display("test boot done");
    endtask
    task automatic t_prec();
        logic [63:0] saved_pc;
        u_pipe.issue(1'b1, EXVEC_KIND_GENERAL, 1'b0, 64'h1000, 1);
        #1;
        chk("cancel", 64'h1, canc);
        chk("vector", 64'hffffffffbfc00180, raddr);
        chk("restart", 64'h1000, ra);
        chk("slot", 64'h0, slot);
        chk("kernel", 64'h1, kmode);
        saved_pc = ra;
        u_pipe.issue(1'b1, EXVEC_KIND_GENERAL, 1'b1, saved_pc + 64'h1004,
                     2);
        #1;
        chk("slot restart", 64'h2000, ra);
        chk("slot set", 64'h1, slot);
        chk("younger dropped", 64'h0, redir);
        $display("test precise done");
    endtask
    task automatic t_kinds();
        exvec_kind_t ks[6] = '{EXVEC_KIND_REFILL, EXVEC_KIND_REFILL,
            EXVEC_KIND_INTERRUPT, EXVEC_KIND_ERROR, EXVEC_KIND_DEBUG,
            EXVEC_KIND_INTERRUPT};
        logic [11:0] os[6] = '{12'h000, 12'h180, 12'h200, 12'h300, 12'h180,
            12'h180};
        logic [63:0] got;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            ctl.exl <= i == 1;
            ctl.interrupt_vector_enable <= i == 2;
            u_pipe.issue(1'b1, ks[i], 1'b0, 64'h3000 + 64'(i * 8), 1);
            #1;
            got = i == 3 ? era : (i == 4 ? dra : ra);
            chk("kind vector", 64'hffffffffbfc00000 | 64'(os[i]), raddr);
            chk("kind restart", 64'h3000 + 64'(i * 8), got);
        end
        $display("test kinds done");
    endtask
    task automatic t_imp();
        u_pipe.issue(1'b0, EXVEC_KIND_GENERAL, 1'b0, 64'h4000, 1);
        repeat (3) @(posedge clk);
        #1;
        chk("imprecise early", 64'h0, imp_t);
        u_pipe.complete(1);
        #1;
        chk("imprecise taken", 64'h1, imp_t);
        chk("imprecise redirect", 64'h1, redir);
        chk("imprecise cancel", 64'h0, canc);
        chk("restart kept", 64'h3028, ra);
        $display("test imprecise done");
    endtask
    task automatic t_modes();
        logic [3:0] cs[5] = '{4'he, 4'h2, 4'h6, 4'h5, 4'h7};
        exvec_mode_t ms[5] = '{EXVEC_MODE_COMPAT, EXVEC_MODE_COMPAT,
            EXVEC_MODE_VECTORED, EXVEC_MODE_EXT_CTRL, EXVEC_MODE_EXT_CTRL};
        wr(3'h4, 32'h1);
        chk("spacing held", 64'h0, vsp);
        @(posedge clk);
        ctl.vectored_support <= 1'b1;
        wr(3'h4, 32'h1);
        chk("spacing", 64'h1, vsp);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            ctl <= '{cs[i][3], cs[i][2], 1'b0, cs[i][1], cs[i][0]};
            repeat (2) @(posedge clk);
            #1;
            chk("mode", ms[i], mode);
            chk("ext flag", cs[i][0], ecfg);
        end
        @(posedge clk);
        ctl <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        repeat (3) @(posedge clk);
        #1;
        chk("spacing cleared", 64'h0, vsp);
        @(posedge clk);
        ctl.vectored_support <= 1'b1;
        wr(3'h4, 32'h0);
        chk("zero spacing mode", EXVEC_MODE_COMPAT, mode);
        @(posedge clk);
        ctl <= '0;
        $display("test modes done");
    endtask
    task automatic t_wide();
        // Software is taken to have enabled the wide kernel segments.
        wr(3'h2, 32'h12345003);
        chk("global base", 64'h12345002, g_rd);
        u_pipe.issue(1'b1, EXVEC_KIND_GENERAL, 1'b0, 64'h5000, 1);
        #1;
        chk("wide vector", 64'h9000000012345180, raddr);
        wr(3'h1, 32'h0abcd000);
        chk("local base", 64'h0abcd000, l_rd);
        u_pipe.issue(1'b1, EXVEC_KIND_RESET, 1'b0, 64'h5008, 1);
        #1;
        chk("local vector", 64'hffffffffaabcd000, raddr);
        wr(3'h1, 32'h0abcd001);
        u_pipe.issue(1'b1, EXVEC_KIND_RESET, 1'b0, 64'h5010, 1);
        #1;
        chk("global select", 64'h9000000012345000, raddr);
        $display("test wide done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_boot();
        t_prec();
        t_kinds();
        t_imp();
        t_modes();
        t_wide();
        print_verdict();
    end
    // The whole sequence takes well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
